// >>> core/flash_status_cfg.svh
`ifndef FLASH_STATUS_CFG_SVH
`define FLASH_STATUS_CFG_SVH

// Register byte offsets on the bus
`define REG_STATUS       8'h00
`define REG_CONFIG       8'h04
`define REG_CTRL         8'h08
`define REG_IRQ_STATUS   8'h0C
`define REG_IRQ_MASK     8'h10
`define REG_QUERY_NEXT   8'h14
`define REG_QUERY_BASE   8'h40
`define REG_QUERY_TOP    8'hBC

// Status register field positions
`define ST_LOCK_BIT      7
`define ST_PERR_BIT      6
`define ST_EERR_BIT      5
`define ST_BP_HI_BIT     4
`define ST_BP_LO_BIT     2
`define ST_WEL_BIT       1
`define ST_BUSY_BIT      0

// Configuration register layout
`define CFG_PSEL_BIT     3
`define CFG_RESET        8'h00
`define CFG_OTP_MASK     8'h28
`define CFG_RW_MASK      8'hC3

// Reset values of the protect bits
`define BP_VOL_RESET     3'h7
`define BP_NV_RESET      3'h0

// Control register fault-injection bits
`define CTRL_FAIL_PROG   0
`define CTRL_FAIL_ERASE  1

// Interrupt bit positions
`define IRQ_DONE         0
`define IRQ_PERR         1
`define IRQ_EERR         2
`define IRQ_REJECT       3
`define IRQ_WIDTH        4

// Link command codes
`define OP_WRITE_REGS    8'h01
`define OP_PROGRAM       8'h02
`define OP_CLEAR_LATCH   8'h04
`define OP_READ_STATUS   8'h05
`define OP_SET_LATCH     8'h06
`define OP_ERASE         8'hD8

// Query padding parameter
`define PAD_ID           8'hF0
`define PAD_LEN          8'h0F
`define PAD_FILL         8'hFF
`define PARAM_LEN_OFS    8'h01

// Internal operation time
`define OP_TIME_NS       2000
`define CLK_PERIOD_NS    4

`endif

// >>> core/flash_status_pkg.sv
package flash_status_pkg;

	// Status byte, bit 7 down to bit 0
	typedef struct packed {
		logic       lock;
		logic       prog_err;
		logic       erase_err;
		logic [2:0] protect;
		logic       write_enable_latch;
		logic       busy;
	} status_t;

	// One captured link frame
	typedef struct packed {
		logic [7:0] opcode;
		logic [7:0] arg1;
		logic [7:0] arg2;
		logic [1:0] nbytes;
	} cmd_frame_t;

	// Internal operation in progress
	typedef enum logic [1:0] {
		ST_IDLE      = 2'b00,
		ST_WRITE_REG = 2'b01,
		ST_PROGRAM   = 2'b10,
		ST_ERASE     = 2'b11
	} op_state_t;

endpackage : flash_status_pkg

// >>> core/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
	parameter int         W         = 1,
	parameter logic [7:0] RESET_VAL = 8'h00
) (
	input  wire logic         clk_i, // System clock
	input  wire logic         rst_i, // Synchronous reset
	input  wire logic [W-1:0] d_i,   // Asynchronous pins
	output logic      [W-1:0] q_o    // Filtered levels
);

	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	generate
		if (W < 1 || W > 8)
		begin : g_chk
			$error("pin_sync width out of range");
		end
	endgenerate

	// Three stages, a change counts when the last two agree
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			s1_q <= RESET_VAL[W-1:0];
			s2_q <= RESET_VAL[W-1:0];
			s3_q <= RESET_VAL[W-1:0];
			q_o  <= RESET_VAL[W-1:0];
		end
		else
		begin
			s1_q <= d_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
			for (int i = 0; i < W; i++)
			begin
				if (s2_q[i] == s3_q[i])
					q_o[i] <= s3_q[i];
			end
		end
	end

endmodule : pin_sync

`default_nettype wire

// >>> core/flash_status_reg.sv
// Function
// - Lock plus low protect pin ignores register write
// - Lock clear means writes allowed whatever the protect pin
// - Program error sets read-only volatile flag
// - Erase error sets read-only volatile flag
// - Protect bits volatile or non-volatile per select
// - Protect bits guard sectors from program, erase
// - Latch set allows register write, program, erase
// - Latch clear ignores register write, program, erase
// - Only latch commands change the latch
// - Busy flag high during internal operations
// - Busy clear means ready for commands
// - Padding parameter fills space with fill bytes
// - Length byte gives start of next parameter
// - Storage select bit is one-time set, default zero
//
// The register addresses and the Wishbone slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "flash_status_cfg.svh"

module flash_status_reg
	import flash_status_pkg::*;
#(
	parameter int SECTORS    = 256,
	parameter int OP_CYCLES  = (`OP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
	input  wire logic        clk_i,   // System clock, 250 MHz
	input  wire logic        rst_i,   // Synchronous reset, volatile state
	input  wire logic        por_i,   // Power-on reset, non-volatile state
	input  wire logic        cyc_i,   // Wishbone cycle
	input  wire logic        stb_i,   // Wishbone strobe
	input  wire logic        we_i,    // Wishbone write
	input  wire logic [7:0]  adr_i,   // Wishbone byte address
	input  wire logic [31:0] dat_i,   // Wishbone write data
	input  wire logic [3:0]  sel_i,   // Wishbone byte lanes
	output logic      [31:0] dat_o,   // Wishbone read data
	output logic             ack_o,   // Wishbone acknowledge
	input  wire logic        sck_i,   // Link clock pin
	input  wire logic        cs_n_i,  // Link select, active low
	input  wire logic        mosi_i,  // Link data in
	input  wire logic        wp_n_i,  // Write-protect pin, active low
	output logic             miso_o,  // Link data out
	output logic             irq_o    // Level interrupt
);

	localparam int SW = $clog2(SECTORS);

	generate
		if (SECTORS < 128 || SECTORS > 256 || (1 << SW) != SECTORS)
		begin : g_chk_sect
			$error("SECTORS must be 128 or 256");
		end
		if (OP_CYCLES < 1 || OP_CYCLES > 65535)
		begin : g_chk_cyc
			$error("OP_CYCLES out of range");
		end
	endgenerate

	// Sector falls inside the range chosen by the protect bits
	function automatic logic sector_locked(input logic [SW-1:0] sec, input logic [2:0] bp);
		logic [SW:0] full;
		logic [SW:0] span;
		full = {1'b1, {SW{1'b0}}};
		span = full >> (3'h7 - bp);
		sector_locked = (bp != 3'h0) && ({1'b0, sec} >= (full - span));
	endfunction : sector_locked

	// Byte of the padding parameter at a relative offset
	function automatic logic [7:0] query_byte(input logic [7:0] idx);
		if (idx == 8'h00)
			query_byte = `PAD_ID;
		else if (idx == `PARAM_LEN_OFS)
			query_byte = `PAD_LEN;
		else if (idx <= `PARAM_LEN_OFS + `PAD_LEN)
			query_byte = `PAD_FILL;
		else
			query_byte = 8'h00;
	endfunction : query_byte

	// Synchronised pins
	logic [3:0] pins_s;
	logic       sck_s;
	logic       cs_act;
	logic       mosi_s;
	logic       wp_s;

	pin_sync #(
		.W         (4),
		.RESET_VAL (8'h0A)
	) u_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   ({wp_n_i, mosi_i, cs_n_i, sck_i}),
		.q_o   (pins_s)
	);

	assign sck_s  = pins_s[0];
	assign cs_act = ~pins_s[1];
	assign mosi_s = pins_s[2];
	assign wp_s   = pins_s[3];

	// Link state
	logic       sck_prev_q;
	logic       cs_prev_q;
	logic [2:0] bit_cnt_q;
	logic [7:0] shift_in_q;
	logic [7:0] shift_out_q;
	cmd_frame_t frame_q;
	logic       sck_rise;
	logic       sck_fall;
	logic       frame_start;
	logic       frame_end;

	// Register state
	logic       lock_q;
	logic       perr_q;
	logic       eerr_q;
	logic [2:0] bp_vol_q;
	logic [2:0] bp_nv_q;
	logic       wel_q;
	logic [7:0] cfg_q;
	logic [7:0] ctrl_q;
	logic [`IRQ_WIDTH-1:0] irq_sts_q;
	logic [`IRQ_WIDTH-1:0] irq_mask_q;
	op_state_t  state_q;
	logic [15:0] cnt_q;
	status_t    status;
	logic [2:0] bp_eff;

	// Command decisions
	logic       idle;
	logic       do_set;
	logic       do_clr;
	logic       wr_req;
	logic       wr_locked;
	logic       do_wrr;
	logic       pe_cmd;
	logic       pe_req;
	logic       pe_hit;
	logic       do_pe;
	logic       reject;
	logic       op_done;
	logic       prog_fail;
	logic       erase_fail;
	logic [7:0] cfg_new;

	// Bus decisions
	logic        bus_req;
	logic        bus_wr;
	logic [7:0]  rd_byte;
	logic [`IRQ_WIDTH-1:0] irq_ev;
	logic [`IRQ_WIDTH-1:0] irq_clr;

	// Link clock and select edges
	assign sck_rise    = cs_act & sck_s & ~sck_prev_q;
	assign sck_fall    = cs_act & ~sck_s & sck_prev_q;
	assign frame_start = cs_act & ~cs_prev_q;
	assign frame_end   = ~cs_act & cs_prev_q;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sck_prev_q <= 1'b0;
			cs_prev_q  <= 1'b0;
		end
		else
		begin
			sck_prev_q <= sck_s;
			cs_prev_q  <= cs_act;
		end
	end

	// Shift in on rising link edges, capture up to three bytes
	always_ff @(posedge clk_i)
	begin
		if (rst_i || frame_start)
		begin
			bit_cnt_q  <= 3'h0;
			shift_in_q <= 8'h00;
			frame_q    <= '0;
		end
		else if (sck_rise)
		begin
			shift_in_q <= {shift_in_q[6:0], mosi_s};
			bit_cnt_q  <= bit_cnt_q + 3'h1;
			if (bit_cnt_q == 3'h7)
			begin
				if (frame_q.nbytes == 2'h0)
					frame_q.opcode <= {shift_in_q[6:0], mosi_s};
				else if (frame_q.nbytes == 2'h1)
					frame_q.arg1 <= {shift_in_q[6:0], mosi_s};
				else if (frame_q.nbytes == 2'h2)
					frame_q.arg2 <= {shift_in_q[6:0], mosi_s};
				if (frame_q.nbytes != 2'h3)
					frame_q.nbytes <= frame_q.nbytes + 2'h1;
			end
		end
	end

	// Status byte out on falling link edges, reloaded every byte
	always_ff @(posedge clk_i)
	begin
		if (rst_i || frame_start)
		begin
			shift_out_q <= 8'h00;
			miso_o      <= 1'b0;
		end
		else if (sck_fall)
		begin
			if (bit_cnt_q == 3'h0 && frame_q.nbytes != 2'h0
				&& frame_q.opcode == `OP_READ_STATUS)
			begin
				miso_o      <= status[7];
				shift_out_q <= {status[6:0], 1'b0};
			end
			else
			begin
				miso_o      <= shift_out_q[7];
				shift_out_q <= {shift_out_q[6:0], 1'b0};
			end
		end
	end

	// Live status byte
	always_comb
	begin
		bp_eff           = cfg_q[`CFG_PSEL_BIT] ? bp_vol_q : bp_nv_q;
		status.lock      = lock_q;
		status.prog_err  = perr_q;
		status.erase_err = eerr_q;
		status.protect   = bp_eff;
		status.write_enable_latch       = wel_q;
		status.busy      = (state_q != ST_IDLE);
	end

	// Commands act at frame end, only when idle
	assign idle      = (state_q == ST_IDLE);
	assign do_set    = frame_end & idle & (frame_q.opcode == `OP_SET_LATCH);
	assign do_clr    = frame_end & idle & (frame_q.opcode == `OP_CLEAR_LATCH);
	assign wr_req    = frame_end & idle & (frame_q.opcode == `OP_WRITE_REGS)
	                   & (frame_q.nbytes >= 2'h2);
	assign wr_locked = lock_q & ~wp_s;
	assign do_wrr    = wr_req & wel_q & ~wr_locked;
	assign pe_cmd    = frame_end & idle & (frame_q.nbytes >= 2'h2)
	                   & ((frame_q.opcode == `OP_PROGRAM) | (frame_q.opcode == `OP_ERASE));
	assign pe_req    = pe_cmd & wel_q;
	assign pe_hit    = pe_req & sector_locked(frame_q.arg1[SW-1:0], bp_eff);
	assign do_pe     = pe_req & ~pe_hit;
	assign reject    = (wr_req & ~do_wrr) | (pe_cmd & ~do_pe);
	assign op_done   = ~idle & (cnt_q == 16'h0000);
	assign prog_fail = (pe_hit & (frame_q.opcode == `OP_PROGRAM))
	                   | (op_done & (state_q == ST_PROGRAM) & ctrl_q[`CTRL_FAIL_PROG]);
	assign erase_fail = (pe_hit & (frame_q.opcode == `OP_ERASE))
	                   | (op_done & (state_q == ST_ERASE) & ctrl_q[`CTRL_FAIL_ERASE]);

	// New configuration: one-time bits only set, reserved bits stay zero
	assign cfg_new = (frame_q.arg2 & `CFG_RW_MASK)
	                 | ((cfg_q | frame_q.arg2) & `CFG_OTP_MASK);

	// Internal operation timer
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_q <= ST_IDLE;
			cnt_q   <= 16'h0000;
		end
		else
		begin
			case (state_q)
				ST_IDLE:
				begin
					cnt_q <= 16'(OP_CYCLES - 1);
					if (do_wrr)
						state_q <= ST_WRITE_REG;
					else if (do_pe && frame_q.opcode == `OP_PROGRAM)
						state_q <= ST_PROGRAM;
					else if (do_pe)
						state_q <= ST_ERASE;
				end
				default:
				begin
					if (op_done)
						state_q <= ST_IDLE;
					else
						cnt_q <= cnt_q - 16'h0001;
				end
			endcase
		end
	end

	// Write-enable latch, touched only by its two commands
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wel_q <= 1'b0;
		else if (do_set)
			wel_q <= 1'b1;
		else if (do_clr)
			wel_q <= 1'b0;
	end

	// Error flags, sticky until the synchronous reset rst_i
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			perr_q <= 1'b0;
			eerr_q <= 1'b0;
		end
		else
		begin
			if (prog_fail)
				perr_q <= 1'b1;
			if (erase_fail)
				eerr_q <= 1'b1;
		end
	end

	// Volatile protect copy, all set after reset
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			bp_vol_q <= `BP_VOL_RESET;
		else if (do_wrr && cfg_q[`CFG_PSEL_BIT])
			bp_vol_q <= frame_q.arg1[`ST_BP_HI_BIT:`ST_BP_LO_BIT];
	end

	// Non-volatile lock, protect bits and configuration
	always_ff @(posedge clk_i)
	begin
		if (por_i)
		begin
			lock_q  <= 1'b0;
			bp_nv_q <= `BP_NV_RESET;
			cfg_q   <= `CFG_RESET;
		end
		else if (do_wrr)
		begin
			lock_q <= frame_q.arg1[`ST_LOCK_BIT];
			if (!cfg_q[`CFG_PSEL_BIT])
				bp_nv_q <= frame_q.arg1[`ST_BP_HI_BIT:`ST_BP_LO_BIT];
			if (frame_q.nbytes == 2'h3)
				cfg_q <= cfg_new;
		end
	end

	// Wishbone request and read mux
	assign bus_req = cyc_i & stb_i & ~ack_o;
	assign bus_wr  = bus_req & we_i & sel_i[0];

	always_comb
	begin
		rd_byte = 8'h00;
		if (adr_i == `REG_STATUS)
			rd_byte = status;
		else if (adr_i == `REG_CONFIG)
			rd_byte = cfg_q;
		else if (adr_i == `REG_CTRL)
			rd_byte = ctrl_q;
		else if (adr_i == `REG_IRQ_STATUS)
			rd_byte = {{(8 - `IRQ_WIDTH){1'b0}}, irq_sts_q};
		else if (adr_i == `REG_IRQ_MASK)
			rd_byte = {{(8 - `IRQ_WIDTH){1'b0}}, irq_mask_q};
		else if (adr_i == `REG_QUERY_NEXT)
			rd_byte = `PARAM_LEN_OFS + `PAD_LEN + 8'h01;
		else if (adr_i >= `REG_QUERY_BASE && adr_i <= `REG_QUERY_TOP)
			rd_byte = query_byte({2'b00, adr_i[7:2] - 6'(`REG_QUERY_BASE >> 2)});
	end

	// Acknowledge one cycle after the request, then drop
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end
		else
		begin
			ack_o <= bus_req;
			if (bus_req)
				dat_o <= {24'h00_0000, rd_byte};
		end
	end

	// Software control and mask registers
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ctrl_q     <= 8'h00;
			irq_mask_q <= '0;
		end
		else if (bus_wr)
		begin
			if (adr_i == `REG_CTRL)
				ctrl_q <= dat_i[7:0] & 8'h03;
			else if (adr_i == `REG_IRQ_MASK)
				irq_mask_q <= dat_i[`IRQ_WIDTH-1:0];
		end
	end

	// Sticky events, set wins over write-one-to-clear
	assign irq_ev[`IRQ_DONE]   = op_done;
	assign irq_ev[`IRQ_PERR]   = prog_fail;
	assign irq_ev[`IRQ_EERR]   = erase_fail;
	assign irq_ev[`IRQ_REJECT] = reject;
	assign irq_clr = (bus_wr && adr_i == `REG_IRQ_STATUS) ? dat_i[`IRQ_WIDTH-1:0] : '0;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			irq_sts_q <= '0;
		else
			irq_sts_q <= (irq_sts_q & ~irq_clr) | irq_ev;
	end

	// Interrupt level from unmasked status
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			irq_o <= 1'b0;
		else
			irq_o <= |(irq_sts_q & irq_mask_q);
	end

endmodule : flash_status_reg

`default_nettype wire

// >>> tb/spi_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module spi_host_model (
	input  wire logic miso_i, // Link data from device
	output logic      sck_o,  // Link clock, low outside frames
	output logic      cs_n_o, // Link select, active low
	output logic      mosi_o  // Link data to device
);
	// Idle link
	initial
	begin
		sck_o = 1'b0;
		cs_n_o = 1'b1;
		mosi_o = 1'b0;
	end

	// One frame of n bytes, MSB first, mode 0
	task automatic send(input logic [23:0] data, input int n, output logic [7:0] rx);
		#13;
		rx = 8'h00;
		cs_n_o = 1'b0;
		for (int i = 0; i < 8 * n; i++)
		begin
			mosi_o = data[23 - i];
			#80 sck_o = 1'b1;
			rx = {rx[6:0], miso_i}; // Sample on the rising link edge
			#80 sck_o = 1'b0;
		end
		mosi_o = ~mosi_o; // Released line shows no stale bit
		#80 cs_n_o = 1'b1;
	endtask : send
endmodule : spi_host_model

`default_nettype wire

// >>> tb/flash_status_reg_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "flash_status_cfg.svh"

module flash_status_reg_checker (
	input wire logic        clk_i, // System clock
	input wire logic        rst_i, // Reset
	input wire logic        cyc_i, // Bus cycle
	input wire logic        stb_i, // Bus strobe
	input wire logic        we_i,  // Bus write
	input wire logic [7:0]  adr_i, // Bus address
	input wire logic [31:0] dat_o, // Read data
	input wire logic        ack_o, // Acknowledge
	input wire logic        irq_o  // Interrupt
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// Read answer in progress
	wire logic rd_ack = ack_o && !we_i;

	chk_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("ack late");
	chk_ack_pulse: assert property (ack_o |=> !ack_o)
		else $error("ack too long");
	chk_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
		else $error("ack without request");
	chk_upper_zero: assert property (rd_ack |-> dat_o[31:8] == 24'h000000)
		else $error("upper read bits set");
	chk_pad_id: assert property (rd_ack && adr_i == `REG_QUERY_BASE |-> dat_o[7:0] == 8'hF0)
		else $error("pad id wrong");
	chk_pad_len: assert property (rd_ack && adr_i == 8'h44 |-> dat_o[7:0] == 8'h0F)
		else $error("pad length wrong");
	chk_pad_fill: assert property (rd_ack && adr_i >= 8'h48 && adr_i <= 8'h80 |-> dat_o[7:0] == 8'hFF)
		else $error("pad fill wrong");
	chk_next_param: assert property (rd_ack && adr_i == `REG_QUERY_NEXT |-> dat_o[7:0] == 8'h11)
		else $error("next offset wrong");
	chk_irq_quiet: assert property ($fell(rst_i) |-> !irq_o)
		else $error("irq after reset");

	// Main scenarios
	cov_query: cover property (rd_ack && adr_i == `REG_QUERY_NEXT);
	cov_irq: cover property ($rose(irq_o));
	cov_write: cover property (ack_o && we_i);
endmodule : flash_status_reg_checker

bind flash_status_reg flash_status_reg_checker chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
	.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o));

`default_nettype wire

// >>> tb/flash_status_reg_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "flash_status_cfg.svh"

module flash_status_reg_tb
	import flash_status_pkg::*;
;
	logic        clk_i = 0, rst_i = 1, por_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, wp_n_i = 1;
	logic [7:0]  adr_i = 0, rd, sec, lrx;
	logic [31:0] dat_i = 0;
	logic [3:0]  sel_i = 0;
	wire logic [31:0] dat_o;
	wire logic   ack_o, miso_o, irq_o, sck, cs_n, mosi;
	logic [23:0] exp_q[$], e;
	int          n_errors = 0, num_checks = 0;

	// 250 MHz clock
	initial forever #2 clk_i = ~clk_i;

	flash_status_reg #(.SECTORS(256), .OP_CYCLES(20)) uut (.clk_i(clk_i), .rst_i(rst_i),
		.por_i(por_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i),
		.sel_i(sel_i), .dat_o(dat_o), .ack_o(ack_o), .sck_i(sck), .cs_n_i(cs_n), .mosi_i(mosi),
		.wp_n_i(wp_n_i), .miso_o(miso_o), .irq_o(irq_o));
	spi_host_model host (.miso_i(miso_o), .sck_o(sck), .cs_n_o(cs_n), .mosi_o(mosi));

	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED %s exp %h seen %h", name, exp, seen);
		end
	endtask : check

	// Classic single bus cycle, held until ack
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
		int t = 0;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= {24'h000000, d};
		sel_i <= 4'hF;
		do @(posedge clk_i); while (ack_o !== 1'b1 && ++t < 50);
		if (ack_o !== 1'b1)
			n_errors++; // Bus answer never came
		rd = dat_o[7:0];
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
		@(posedge clk_i);
	endtask : xfer

	task automatic rdc(input logic [7:0] a, input logic [7:0] x, input logic [7:0] m);
		exp_q.push_back({a, m, x});
		xfer(1'b0, a, 8'h00);
	endtask : rdc

	// Host polls busy before the next command
	task automatic frame(input logic [23:0] d, input int n, input bit idle);
		host.send(d, n, lrx);
		repeat (12) @(posedge clk_i);
		for (int k = 0; idle && k < 100; k++)
		begin
			xfer(1'b0, `REG_STATUS, 8'h00);
			if (rd[0] === 1'b0)
				break;
		end
		if (idle) check("idle", {7'h00, rd[0]}, 8'h00);
	endtask : frame

	task automatic finish_test;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : finish_test

	// Read monitor compares with oldest note
	always @(posedge clk_i)
		if (ack_o === 1'b1 && we_i === 1'b0 && exp_q.size() > 0)
		begin
			e = exp_q.pop_front();
			check($sformatf("reg %h", e[23:16]), dat_o[7:0] & e[15:8], e[7:0]);
		end

	// Watchdog
	initial
	begin
		#300000;
		n_errors++;
		finish_test();
	end

	// Main sequence
	initial
	begin
		void'($urandom(24));
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		por_i <= 1'b0;
		repeat (6) @(posedge clk_i);
		rdc(`REG_STATUS, 8'h00, 8'hFF);
		rdc(`REG_CONFIG, 8'h00, 8'hFF);
		for (int i = 0; i < 32; i++)
			rdc(`REG_QUERY_BASE + 8'(4 * i), i == 0 ? 8'hF0 : i == 1 ? 8'h0F : i < 17 ? 8'hFF : 8'h00, 8'hFF);
		rdc(`REG_QUERY_NEXT, 8'h11, 8'hFF);
		rdc(8'h20, 8'h00, 8'hFF);
		xfer(1'b1, `REG_IRQ_MASK, 8'h0F);
		frame({`OP_WRITE_REGS, 16'h9C00}, 2, 0);
		rdc(`REG_STATUS, 8'h00, 8'hFF);
		rdc(`REG_IRQ_STATUS, 8'h08, 8'h08);
		check("irq on", {7'h00, irq_o}, 8'h01);
		xfer(1'b1, `REG_IRQ_MASK, 8'h00);
		repeat (2) @(posedge clk_i);
		check("irq masked", {7'h00, irq_o}, 8'h00);
		xfer(1'b1, `REG_IRQ_STATUS, 8'h0F);
		rdc(`REG_IRQ_STATUS, 8'h00, 8'h08);
		xfer(1'b1, `REG_IRQ_MASK, 8'h0F);
		frame({`OP_SET_LATCH, 16'h0000}, 1, 0);
		rdc(`REG_STATUS, 8'h02, 8'hFF);
		frame({`OP_WRITE_REGS, 16'hFF00}, 2, 0);
		rdc(`REG_STATUS, 8'h01, 8'h01);
		frame(24'h000000, 0, 1);
		rdc(`REG_STATUS, 8'h9E, 8'hFF);
		frame({`OP_READ_STATUS, 16'h0000}, 2, 0);
		check("link status", lrx, 8'h9E);
		wp_n_i <= 1'b0;
		frame({`OP_WRITE_REGS, 16'h0000}, 2, 1);
		rdc(`REG_STATUS, 8'h9E, 8'hFF);
		wp_n_i <= 1'b1;
		frame({`OP_WRITE_REGS, 16'h0000}, 2, 1);
		wp_n_i <= 1'b0;
		rdc(`REG_STATUS, 8'h02, 8'hFF);
		frame({`OP_WRITE_REGS, 16'h1C00}, 2, 1);
		rdc(`REG_STATUS, 8'h1E, 8'hFF);
		sec = 8'($urandom);
		frame({`OP_PROGRAM, sec, 8'h00}, 2, 0);
		rdc(`REG_STATUS, 8'h5E, 8'hFF);
		frame({`OP_ERASE, sec, 8'h00}, 2, 0);
		rdc(`REG_STATUS, 8'h7E, 8'hFF);
		rst_i <= 1'b1;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (6) @(posedge clk_i);
		rdc(`REG_STATUS, 8'h1C, 8'hFF);
		frame({`OP_SET_LATCH, 16'h0000}, 1, 0);
		frame({`OP_WRITE_REGS, 16'h0008}, 3, 1);
		rdc(`REG_CONFIG, 8'h08, 8'h08);
		rdc(`REG_STATUS, 8'h1E, 8'hFF);
		frame({`OP_WRITE_REGS, 16'h0000}, 2, 1);
		rdc(`REG_STATUS, 8'h02, 8'hFF);
		xfer(1'b1, `REG_CTRL, 8'h01);
		xfer(1'b1, `REG_IRQ_STATUS, 8'h0F);
		frame({`OP_PROGRAM, 8'($urandom), 8'h00}, 2, 1);
		rdc(`REG_STATUS, 8'h42, 8'hFF);
		rdc(`REG_IRQ_STATUS, 8'h03, 8'h0F);
		frame({`OP_CLEAR_LATCH, 16'h0000}, 1, 0);
		rdc(`REG_STATUS, 8'h40, 8'hFF);
		rst_i <= 1'b1;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (6) @(posedge clk_i);
		rdc(`REG_STATUS, 8'h1C, 8'hFF);
		finish_test();
	end
endmodule : flash_status_reg_tb

`default_nettype wire
